// ### sie_pkg.sv
// Constants and types shared by the interrupt enable block
package sie_pkg;
	localparam int SIE_NUM_SRC = 6;
	localparam int SIE_DATA_W = 32;
	localparam int SIE_ADDR_W = 32;
	localparam int SIE_STRB_W = 4;
	// Register byte addresses
	localparam logic [SIE_ADDR_W-1:0] SIE_ADDR_STATUS = 32'h4005_8008;
	localparam logic [SIE_ADDR_W-1:0] SIE_ADDR_SET = 32'h4005_800C;
	localparam logic [SIE_ADDR_W-1:0] SIE_ADDR_CLEAR = 32'h4005_8010;
	// Field positions within the enable and status words, and the write strobe lane of the enables
	localparam int SIE_BIT_RX_READY = 0;
	localparam int SIE_BIT_TX_READY = 1;
	localparam int SIE_BIT_RX_OVERRUN = 2;
	localparam int SIE_BIT_TX_UNDERRUN = 3;
	localparam int SIE_BIT_SEL_ASSERT = 4;
	localparam int SIE_BIT_SEL_DEASSERT = 5;
	localparam int SIE_LANE_ENABLES = 0;
	// Reset values
	localparam logic [SIE_NUM_SRC-1:0] SIE_ENABLE_RST = 6'h00;
	localparam logic [SIE_NUM_SRC-1:0] SIE_STATUS_RST = 6'h00;
	localparam logic [SIE_DATA_W-1:0] SIE_RDATA_ZERO = 32'h0000_0000;

	// Source events; bit order matches the enable word
	typedef struct packed {
		logic select_deassert;
		logic select_assert;
		logic tx_underrun;
		logic rx_overrun;
		logic tx_ready;
		logic rx_ready;
	} sie_events_t;

	// Raw inputs from the data path
	typedef struct packed {
		logic tx_underrun;
		logic rx_overrun;
		logic tx_ready;
		logic rx_ready;
	} sie_path_t;

	typedef enum logic {
		SIE_MODE_MASTER,
		SIE_MODE_SLAVE
	} sie_mode_t;
endpackage

// ### sie_sel_edge.sv
// Slave select activity detector: any-asserted and all-deasserted pulses
`timescale 1ns/1ps
module sie_sel_edge
	import sie_pkg::*;
#(
	parameter int NUM_SEL = 4
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [NUM_SEL-1:0] sel_active_i,
	output logic assert_o,
	output logic deassert_o
);
	logic [NUM_SEL-1:0] prev;
	logic [NUM_SEL-1:0] next_prev;
	logic next_assert;
	logic next_deassert;

	always_comb begin
		next_prev = sel_active_i;
		// Any line going from inactive to active
		next_assert = |(sel_active_i & ~prev);
		// Something was active and now nothing is
		next_deassert = (|prev) && !(|sel_active_i);
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev <= '0;
			assert_o <= 1'b0;
			deassert_o <= 1'b0;
		end else begin
			prev <= next_prev;
			assert_o <= next_assert;
			deassert_o <= next_deassert;
		end
	end
endmodule // sie_sel_edge

// ### sie_irq_enable.sv
// SPI interrupt enable set/clear registers, sticky status and interrupt request
`timescale 1ns/1ps
module sie_irq_enable
	import sie_pkg::*;
#(
	parameter int NUM_SEL = 4
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [SIE_ADDR_W-1:0] paddr_i,
	input wire logic [SIE_DATA_W-1:0] pwdata_i,
	input wire logic [SIE_STRB_W-1:0] pstrb_i,
	input wire sie_path_t path_i,
	input wire sie_mode_t mode_i,
	input wire logic [NUM_SEL-1:0] sel_active_i,
	output logic [SIE_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o,
	output logic tx_start_hold_o
);
	logic [SIE_NUM_SRC-1:0] enable;
	logic [SIE_NUM_SRC-1:0] next_enable;
	logic [SIE_NUM_SRC-1:0] status;
	logic [SIE_NUM_SRC-1:0] next_status;
	logic [SIE_DATA_W-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_irq;
	logic next_hold;
	logic sel_assert;
	logic sel_deassert;
	logic setup;
	logic done;
	logic wr_done;
	logic rd_done;
	logic lane_ok;
	sie_events_t events;

	function automatic logic addr_mapped(input logic [SIE_ADDR_W-1:0] a);
		return (a == SIE_ADDR_STATUS) || (a == SIE_ADDR_SET) || (a == SIE_ADDR_CLEAR);
	endfunction

	function automatic logic [SIE_NUM_SRC-1:0] low_bits(input logic [SIE_DATA_W-1:0] d);
		return d[SIE_NUM_SRC-1:0];
	endfunction

	function automatic logic [SIE_DATA_W-1:0] widen(input logic [SIE_NUM_SRC-1:0] v);
		return {{(SIE_DATA_W-SIE_NUM_SRC){1'b0}}, v};
	endfunction

	sie_sel_edge #(
		.NUM_SEL(NUM_SEL)
	) u_sel_edge (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.sel_active_i(sel_active_i),
		.assert_o(sel_assert),
		.deassert_o(sel_deassert)
	);

	// Bus phase decode
	always_comb begin
		setup = psel_i && !penable_i;
		done = psel_i && penable_i && pready_o;
		wr_done = done && pwrite_i;
		rd_done = done && !pwrite_i;
		lane_ok = pstrb_i[SIE_LANE_ENABLES];
	end

	// Event qualification; overrun and underrun exist only as slave
	always_comb begin
		events.rx_ready = path_i.rx_ready;
		events.tx_ready = path_i.tx_ready;
		events.rx_overrun = path_i.rx_overrun && (mode_i == SIE_MODE_SLAVE);
		events.tx_underrun = path_i.tx_underrun && (mode_i == SIE_MODE_SLAVE);
		events.select_assert = sel_assert;
		events.select_deassert = sel_deassert;
	end

	// Enable set/clear; only ones act, zeros leave bits alone
	always_comb begin
		next_enable = enable;
		if (wr_done && lane_ok && paddr_i == SIE_ADDR_SET) begin
			next_enable = enable | low_bits(pwdata_i);
		end
		if (wr_done && lane_ok && paddr_i == SIE_ADDR_CLEAR) begin
			next_enable = enable & ~low_bits(pwdata_i);
		end
	end

	// Sticky status; a new event wins over the read clear
	always_comb begin
		next_status = status;
		if (rd_done && paddr_i == SIE_ADDR_STATUS) begin
			next_status = SIE_STATUS_RST;
		end
		next_status = next_status | events;
	end

	// Registered answer, ready in the access phase
	always_comb begin
		next_pready = setup;
		next_pslverr = setup && !addr_mapped(paddr_i);
		next_prdata = SIE_RDATA_ZERO;
		if (setup && !pwrite_i) begin
			unique case (paddr_i)
				SIE_ADDR_SET: next_prdata = widen(enable);
				SIE_ADDR_STATUS: next_prdata = widen(status);
				default: next_prdata = SIE_RDATA_ZERO;
			endcase
		end
	end

	// Request and master-mode overrun guard
	always_comb begin
		next_irq = |(next_status & next_enable);
		next_hold = (mode_i == SIE_MODE_MASTER) && path_i.rx_ready;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enable <= SIE_ENABLE_RST;
			status <= SIE_STATUS_RST;
			prdata_o <= SIE_RDATA_ZERO;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			irq_o <= 1'b0;
			tx_start_hold_o <= 1'b0;
		end else begin
			enable <= next_enable;
			status <= next_status;
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			irq_o <= next_irq;
			tx_start_hold_o <= next_hold;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_setup_read(logic [SIE_ADDR_W-1:0] a);
		psel_i && !penable_i && !pwrite_i && paddr_i == a;
	endsequence

	sequence s_write_done(logic [SIE_ADDR_W-1:0] a);
		psel_i && penable_i && pready_o && pwrite_i && pstrb_i[SIE_LANE_ENABLES] && paddr_i == a;
	endsequence

	sequence s_quiet_bus;
		!(psel_i && penable_i && pready_o && pwrite_i);
	endsequence

	sequence s_read_done(logic [SIE_ADDR_W-1:0] a);
		psel_i && penable_i && pready_o && !pwrite_i && paddr_i == a;
	endsequence

	sequence s_setup_any;
		psel_i && !penable_i;
	endsequence

	a_irq_or_and: assert property (irq_o == |(status & enable))
		else $error("irq does not match flags and enables");

	a_underrun_irq: assert property (
		(mode_i == SIE_MODE_SLAVE && path_i.tx_underrun && enable[SIE_BIT_TX_UNDERRUN]) and s_quiet_bus
		|=> irq_o)
		else $error("underrun with enable set gave no irq");

	a_underrun_off: assert property (
		(!enable[SIE_BIT_TX_UNDERRUN] && (status & enable) == SIE_STATUS_RST
		&& !(|(events & enable))) and s_quiet_bus |=> !irq_o)
		else $error("irq raised without an enabled source");

	a_master_no_ur: assert property (
		mode_i == SIE_MODE_MASTER && !status[SIE_BIT_TX_UNDERRUN] |=> !status[SIE_BIT_TX_UNDERRUN])
		else $error("underrun flagged in master mode");

	a_sel_assert: assert property (
		($rose(|sel_active_i) && !$past(|sel_active_i) && enable[SIE_BIT_SEL_ASSERT]) and s_quiet_bus
		|=> ##1 (irq_o || !enable[SIE_BIT_SEL_ASSERT]))
		else $error("select assert irq missing");

	a_sel_deassert: assert property (
		($fell(|sel_active_i) && enable[SIE_BIT_SEL_DEASSERT]) and s_quiet_bus
		|=> ##1 (status[SIE_BIT_SEL_DEASSERT] && (irq_o || !enable[SIE_BIT_SEL_DEASSERT])))
		else $error("select deassert irq missing");

	a_reserved_zero: assert property (
		s_setup_read(SIE_ADDR_SET) |=> pready_o && prdata_o[SIE_DATA_W-1:SIE_NUM_SRC] == '0
		&& prdata_o[SIE_NUM_SRC-1:0] == enable)
		else $error("set register read wrong");

	a_clear_write: assert property (s_write_done(SIE_ADDR_CLEAR)
		|=> enable == ($past(enable) & ~$past(pwdata_i[SIE_NUM_SRC-1:0])))
		else $error("clear write did not drop the written ones");

	a_set_write: assert property (s_write_done(SIE_ADDR_SET)
		|=> enable == ($past(enable) | $past(pwdata_i[SIE_NUM_SRC-1:0])))
		else $error("set write did not add the written ones");

	a_clear_reads_zero: assert property (s_setup_read(SIE_ADDR_CLEAR)
		|=> pready_o && prdata_o == '0 && !pslverr_o)
		else $error("clear register read not zero");

	a_rx_ready_irq: assert property (
		(path_i.rx_ready && enable[SIE_BIT_RX_READY]) and s_quiet_bus
		|=> irq_o)
		else $error("rx ready irq missing");

	a_tx_ready_irq: assert property (
		(path_i.tx_ready && enable[SIE_BIT_TX_READY]) and s_quiet_bus
		|=> irq_o)
		else $error("tx ready irq missing");

	a_overrun_irq: assert property (
		(mode_i == SIE_MODE_SLAVE && path_i.rx_overrun && enable[SIE_BIT_RX_OVERRUN]) and s_quiet_bus
		|=> irq_o)
		else $error("overrun with enable set gave no irq");

	a_master_no_ov: assert property (
		mode_i == SIE_MODE_MASTER && !status[SIE_BIT_RX_OVERRUN] |=> !status[SIE_BIT_RX_OVERRUN])
		else $error("overrun flagged in master mode");

	a_rx_ready_set: assert property (path_i.rx_ready |=> status[SIE_BIT_RX_READY])
		else $error("rx ready flag not set");

	a_tx_ready_set: assert property (path_i.tx_ready |=> status[SIE_BIT_TX_READY])
		else $error("tx ready flag not set");

	a_overrun_set: assert property (
		mode_i == SIE_MODE_SLAVE && path_i.rx_overrun |=> status[SIE_BIT_RX_OVERRUN])
		else $error("overrun flag not set");

	a_underrun_set: assert property (
		mode_i == SIE_MODE_SLAVE && path_i.tx_underrun |=> status[SIE_BIT_TX_UNDERRUN])
		else $error("underrun flag not set");

	a_sel_assert_set: assert property (sel_assert |=> status[SIE_BIT_SEL_ASSERT])
		else $error("select assert flag not set");

	a_sel_release_set: assert property (sel_deassert |=> status[SIE_BIT_SEL_DEASSERT])
		else $error("select deassert flag not set");

	a_status_read_clear: assert property (
		s_setup_read(SIE_ADDR_STATUS) ##1 s_read_done(SIE_ADDR_STATUS)
		|=> status == $past(events))
		else $error("status not cleared by its read");

	a_status_read_data: assert property (
		s_setup_read(SIE_ADDR_STATUS)
		|=> prdata_o[SIE_NUM_SRC-1:0] == $past(status))
		else $error("status read data wrong");

	a_status_sticky: assert property (
		!(psel_i && penable_i && pready_o && !pwrite_i && paddr_i == SIE_ADDR_STATUS)
		|=> (status & $past(status)) == $past(status))
		else $error("status bit lost without a read");

	a_enable_stable: assert property (s_quiet_bus |=> enable == $past(enable))
		else $error("enable changed without a write");

	a_clear_zero_keep: assert property (
		s_write_done(SIE_ADDR_CLEAR) ##0 pwdata_i[SIE_NUM_SRC-1:0] == '0
		|=> enable == $past(enable))
		else $error("clear write of zeros changed enables");

	a_set_zero_keep: assert property (
		s_write_done(SIE_ADDR_SET) ##0 pwdata_i[SIE_NUM_SRC-1:0] == '0
		|=> enable == $past(enable))
		else $error("set write of zeros changed enables");

	a_strobe_off: assert property (
		psel_i && penable_i && pready_o && pwrite_i && !pstrb_i[SIE_LANE_ENABLES]
		|=> enable == $past(enable))
		else $error("write without strobe changed enables");

	a_status_no_write: assert property (
		psel_i && penable_i && pready_o && pwrite_i && paddr_i == SIE_ADDR_STATUS
		|=> enable == $past(enable))
		else $error("status write changed enables");

	a_unmapped_err: assert property (
		s_setup_any ##0 !addr_mapped(paddr_i)
		|=> pready_o && pslverr_o && prdata_o == SIE_RDATA_ZERO)
		else $error("unmapped access not refused");

	a_mapped_no_err: assert property (
		s_setup_any ##0 addr_mapped(paddr_i)
		|=> pready_o && !pslverr_o)
		else $error("mapped access flagged as error");

	a_write_no_data: assert property (
		psel_i && !penable_i && pwrite_i
		|=> prdata_o == SIE_RDATA_ZERO)
		else $error("read data driven on a write");

	a_idle_outputs: assert property (!pready_o |-> !pslverr_o && prdata_o == SIE_RDATA_ZERO)
		else $error("bus answer outside access phase");

	a_ready_idle: assert property (!(psel_i && !penable_i) |=> !pready_o)
		else $error("ready without a setup cycle");

	a_reserved_read: assert property (
		pready_o |-> prdata_o[SIE_DATA_W-1:SIE_NUM_SRC] == '0)
		else $error("reserved read bits not zero");

	a_hold_release: assert property (
		mode_i == SIE_MODE_MASTER && !path_i.rx_ready |=> !tx_start_hold_o)
		else $error("hold kept while receive empty");

	a_master_hold: assert property (mode_i == SIE_MODE_MASTER && path_i.rx_ready |=> tx_start_hold_o)
		else $error("master did not hold while receive full");

	a_slave_no_hold: assert property (mode_i == SIE_MODE_SLAVE |=> !tx_start_hold_o)
		else $error("hold raised in slave mode");

	a_ready_one: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("ready not a single access-phase cycle");
endmodule // sie_irq_enable

// ### sie_irq_enable_tb_top.sv
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ps
module sie_irq_enable_tb_top;
	import sie_pkg::*;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0] pstrb_i = 4'hF;
	sie_path_t path_i = 4'h0;
	sie_mode_t mode_i = SIE_MODE_SLAVE;
	logic [3:0] sel_active_i = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic irq_o;
	logic tx_start_hold_o;
	logic [31:0] rd;
	logic err;
	int num_errors = 0;
	int num_checks = 0;

	sie_irq_enable #(.NUM_SEL(4)) sie_irq_enable_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .path_i(path_i), .mode_i(mode_i),
		.sel_active_i(sel_active_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .irq_o(irq_o), .tx_start_hold_o(tx_start_hold_o));

	initial begin
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		i = 0;
		do begin
			@(posedge core_clk_i);
			i++;
		end while (pready_o !== 1'b1 && i < 16);
		if (pready_o !== 1'b1) begin
			num_errors++;
			$display("Error pready expected 1 seen %b", pready_o);
			end_of_test();
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Event high for one cycle, then interrupt level checked
	task automatic pulse(input logic [3:0] ev, input logic exp);
		@(posedge core_clk_i);
		path_i <= sie_path_t'(ev);
		@(posedge core_clk_i);
		path_i <= sie_path_t'(4'h0);
		@(negedge core_clk_i);
		chk("irq event", exp, irq_o);
	endtask

	task automatic sel_step(input logic [3:0] v, input logic exp);
		@(posedge core_clk_i);
		sel_active_i <= v;
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i);
		chk("irq select", exp, irq_o);
	endtask

	initial begin
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		apb(1'b0, SIE_ADDR_SET, 32'h0, 4'hF);
		chk("enable reset", 32'h0, rd);
		apb(1'b1, SIE_ADDR_SET, 32'h0000_003F, 4'hF);
		apb(1'b0, SIE_ADDR_SET, 32'h0, 4'hF);
		chk("enable set", 32'h3F, rd);
		apb(1'b1, SIE_ADDR_CLEAR, 32'h0000_0005, 4'hF);
		apb(1'b0, SIE_ADDR_SET, 32'h0, 4'hF);
		chk("enable clear", 32'h3A, rd);
		apb(1'b0, SIE_ADDR_CLEAR, 32'h0, 4'hF);
		chk("clear read", 32'h0, rd);
		apb(1'b1, SIE_ADDR_CLEAR, 32'h3A, 4'h0);
		apb(1'b0, SIE_ADDR_SET, 32'h0, 4'hF);
		chk("strobe off", 32'h3A, rd);
		apb(1'b0, 32'h4005_8014, 32'h0, 4'hF);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, SIE_ADDR_CLEAR, 32'h3F, 4'hF);
		for (int b = 0; b < 4; b++) begin
			pulse(4'(1 << b), 1'b0);
			apb(1'b0, SIE_ADDR_STATUS, 32'h0, 4'hF);
			chk("status", 32'(1 << b), rd);
			apb(1'b1, SIE_ADDR_SET, 32'(1 << b), 4'hF);
			pulse(4'(1 << b), 1'b1);
			apb(1'b0, SIE_ADDR_STATUS, 32'h0, 4'hF);
			chk("status", 32'(1 << b), rd);
			@(negedge core_clk_i);
			chk("irq cleared", 1'b0, irq_o);
			apb(1'b1, SIE_ADDR_CLEAR, 32'h3F, 4'hF);
		end
		chk("tx start hold slave", 1'b0, tx_start_hold_o);
		@(posedge core_clk_i);
		mode_i <= SIE_MODE_MASTER;
		apb(1'b1, SIE_ADDR_SET, 32'h0C, 4'hF);
		pulse(4'hC, 1'b0);
		pulse(4'h1, 1'b0);
		chk("tx start hold", 1'b1, tx_start_hold_o);
		apb(1'b0, SIE_ADDR_STATUS, 32'h0, 4'hF);
		chk("status master", 32'h1, rd);
		apb(1'b1, SIE_ADDR_CLEAR, 32'h3F, 4'hF);
		sel_step(4'h1, 1'b0);
		sel_step(4'h0, 1'b0);
		apb(1'b0, SIE_ADDR_STATUS, 32'h0, 4'hF);
		chk("status select", 32'h30, rd);
		apb(1'b1, SIE_ADDR_SET, 32'h30, 4'hF);
		sel_step(4'h2, 1'b1);
		apb(1'b0, SIE_ADDR_STATUS, 32'h0, 4'hF);
		chk("status assert", 32'h10, rd);
		sel_step(4'h0, 1'b1);
		apb(1'b0, SIE_ADDR_STATUS, 32'h0, 4'hF);
		chk("status release", 32'h20, rd);
		end_of_test();
	end
endmodule // sie_irq_enable_tb_top
